// file: rtl/acv_regs.svh
// Purpose: timing counts, field positions and reset values of the converter bus control
// Assumes: 100 MHz mclk_i, 4-channel multiplexer, 5-bit multiplexer address latch
// Notes: cycle counts assume the 100 MHz clock
// Operation
// [R1] multiplexer mode and channel come from the bus-loaded address latch
// [R2] address inputs share low five data lines, taken while read strobe high
// [R3] host starts a conversion with chip select and load strobe
// [R4] completion flag stays low until the earlier result is read
// [R5] load strobe falling edge returns completion flag high, readies conversion
// [R6] load strobe rising edge with read high captures address, starts conversion
// [R7] read low through whole load pulse keeps setting, drives previous result
// [R8] at conversion end result moves to output latch, completion flag low
// [R9] conversion lasts no more than forty microseconds
// [R10] chip select and read low raise completion flag and drive result
// [R11] read strobe rising releases the data bus
// [R12] negative input at or above positive input gives all-zero code
// [R13] single-ended references ground, pseudo-differential references fourth channel
// [R14] host keeps chip select low for the whole load strobe pulse
`ifndef ACV_REGS_SVH
`define ACV_REGS_SVH

`define ACV_CLK_PERIOD_NS 10
`define ACV_CONV_TIME_NS 40000
`define ACV_CONV_CYC (`ACV_CONV_TIME_NS / `ACV_CLK_PERIOD_NS)
`define ACV_SAR_BITS 8
`define ACV_STEP_CYC (`ACV_CONV_CYC / `ACV_SAR_BITS)

`define ACV_CFG_W 5
`define ACV_MODE_MSB 3
`define ACV_MODE_LSB 2
`define ACV_PAIR_BIT 1
`define ACV_SWAP_BIT 0

`define ACV_CFG_RST 5'h00
`define ACV_RESULT_RST 8'h00
`define ACV_DONE_N_RST 1'b1

`endif

// file: rtl/acv_pkg.sv
// Purpose: types shared by the converter bus control
// Assumes: four 8-bit channel samples
// Notes: one-hot state codes
package acv_pkg;

  typedef struct packed {
    logic cs_b;
    logic wr_b;
    logic rd_b;
  } acv_host_s;

  typedef logic [3:0][7:0] acv_chan_t;
  typedef logic [4:0] acv_cfg_t;

  typedef enum logic [1:0] {
    CTL_IDLE = 2'h1,
    CTL_WRLOW = 2'h2
  } acv_ctl_e;

  typedef enum logic [1:0] {
    SAR_IDLE = 2'h1,
    SAR_RUN = 2'h2
  } acv_sar_e;

endpackage

// file: rtl/acv_mux.sv
// Purpose: multiplexer decode and differential input selection
// Assumes: channel samples are unsigned codes, ground reads as zero
// Notes: combinational only
`timescale 1ns/1ns
`default_nettype none
`include "acv_regs.svh"
module acv_mux (
  input wire acv_pkg::acv_cfg_t cfg_i,
  input wire acv_pkg::acv_chan_t ch_i,
  output logic [7:0] pos_o,
  output logic [7:0] neg_o,
  output logic [7:0] diff_o
);
  import acv_pkg::*;

  logic [1:0] mode;
  logic [1:0] base;

  always_comb begin
    mode = cfg_i[`ACV_MODE_MSB:`ACV_MODE_LSB];
    base = {cfg_i[`ACV_PAIR_BIT], 1'b0};
    // [R13] reference per mode
    case (mode)
      2'h1: begin
        pos_o = ch_i[cfg_i[1:0]];
        neg_o = 8'h00;
      end
      2'h3: begin
        pos_o = ch_i[cfg_i[1:0]];
        neg_o = ch_i[3];
      end
      default: begin
        pos_o = ch_i[base | {1'b0, cfg_i[`ACV_SWAP_BIT]}];
        neg_o = ch_i[base | {1'b0, ~cfg_i[`ACV_SWAP_BIT]}];
      end
    endcase
    // [R12] clamp to zero
    diff_o = (pos_o > neg_o) ? pos_o - neg_o : 8'h00;
  end

endmodule
`default_nettype wire

// file: rtl/acv_sar.sv
// Purpose: successive approximation sequencer, one bit per step
// Assumes: input difference held steady during a conversion
// Notes: start restarts a running conversion
`timescale 1ns/1ns
`default_nettype none
`include "acv_regs.svh"
module acv_sar (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire logic [7:0] diff_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] code_o
);
  import acv_pkg::*;

  localparam logic [8:0] STEP_LAST = 9'(`ACV_STEP_CYC - 1);

  acv_sar_e state_q, state_d;
  logic [7:0] code_q, code_d, trial;
  logic [2:0] bit_q, bit_d;
  logic [8:0] cnt_q, cnt_d;

  // [R9] eight timed steps
  always_comb begin
    state_d = state_q;
    code_d = code_q;
    bit_d = bit_q;
    cnt_d = cnt_q;
    done_o = 1'b0;
    trial = code_q | (8'h01 << bit_q);
    if (start_i) begin
      state_d = SAR_RUN;
      code_d = 8'h00;
      bit_d = 3'h7;
      cnt_d = 9'h000;
    end else begin
      case (state_q)
        SAR_RUN: begin
          if (cnt_q == STEP_LAST) begin
            cnt_d = 9'h000;
            if (trial <= diff_i) begin
              code_d = trial;
            end
            if (bit_q == 3'h0) begin
              state_d = SAR_IDLE;
              done_o = 1'b1;
            end else begin
              bit_d = bit_q - 3'h1;
            end
          end else begin
            cnt_d = cnt_q + 9'h001;
          end
        end
        default: begin
          state_d = SAR_IDLE;
        end
      endcase
    end
    busy_o = (state_q == SAR_RUN);
    code_o = code_d;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= SAR_IDLE;
      code_q <= 8'h00;
      bit_q <= 3'h7;
      cnt_q <= 9'h000;
    end else if (clk_en_i) begin
      state_q <= state_d;
      code_q <= code_d;
      bit_q <= bit_d;
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// file: rtl/acv_ctrl.sv
// Purpose: bus-side control of an 8-bit converter with input multiplexer
// Assumes: host strobes synchronous to mclk_i, channel samples supplied as codes
// Notes: bus pins split into input, output and output enable
`timescale 1ns/1ns
`default_nettype none
`include "acv_regs.svh"
module acv_ctrl (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire acv_pkg::acv_host_s host_i,
  input wire logic [7:0] result_bus_i,
  output logic [7:0] result_bus_o,
  output logic result_bus_oe_o,
  output logic conversion_done_n_o,
  input wire acv_pkg::acv_chan_t ch_sample_i,
  output acv_pkg::acv_cfg_t mux_cfg_o,
  output logic converting_o
);
  import acv_pkg::*;

  // ==========================================================
  // strobe decode
  // ==========================================================
  acv_ctl_e ctl_q, ctl_d;
  logic wr_prev_q, wr_prev_d;
  logic wr_fall, wr_rise, read_active;
  logic [4:0] mux_select_inputs;

  // [R2] low lines carry the address
  assign mux_select_inputs = result_bus_i[4:0];
  assign wr_fall = wr_prev_q && !host_i.wr_b && !host_i.cs_b;
  // [R14] chip select low at both edges
  assign wr_rise = (ctl_q == CTL_WRLOW) && host_i.wr_b && !host_i.cs_b;
  assign read_active = !host_i.cs_b && !host_i.rd_b;

  // [R3] start via select and load strobe
  always_comb begin
    ctl_d = ctl_q;
    wr_prev_d = host_i.wr_b;
    case (ctl_q)
      CTL_WRLOW: begin
        if (host_i.wr_b) begin
          ctl_d = CTL_IDLE;
        end
      end
      default: begin
        if (wr_fall) begin
          ctl_d = CTL_WRLOW;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_q <= CTL_IDLE;
      wr_prev_q <= 1'b1;
    end else if (clk_en_i) begin
      ctl_q <= ctl_d;
      wr_prev_q <= wr_prev_d;
    end
  end

  // ==========================================================
  // multiplexer address latch
  // ==========================================================
  acv_cfg_t cfg_q, cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    // [R6] capture on rise with read high
    if (wr_rise && host_i.rd_b) begin
      cfg_d = mux_select_inputs;
    end
    // [R7] read low keeps the old setting
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q <= `ACV_CFG_RST;
    end else if (clk_en_i) begin
      cfg_q <= cfg_d;
    end
  end

  assign mux_cfg_o = cfg_q;

  // ==========================================================
  // input selection and conversion
  // ==========================================================
  logic [7:0] mux_pos, mux_neg, mux_diff;
  logic sar_busy, sar_done, sar_start;
  logic [7:0] sar_code;

  // [R1] selection follows the latch
  acv_mux u_mux (
    .cfg_i(cfg_q),
    .ch_i(ch_sample_i),
    .pos_o(mux_pos),
    .neg_o(mux_neg),
    .diff_o(mux_diff)
  );

  assign sar_start = wr_rise;

  acv_sar u_sar (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .start_i(sar_start),
    .diff_i(mux_diff),
    .busy_o(sar_busy),
    .done_o(sar_done),
    .code_o(sar_code)
  );

  assign converting_o = sar_busy;

  // ==========================================================
  // output latch and completion flag
  // ==========================================================
  logic [7:0] result_q, result_d;
  logic done_n_q, done_n_d;

  always_comb begin
    result_d = result_q;
    done_n_d = done_n_q;
    // [R5] falling load strobe raises flag
    // [R10] read raises flag
    if (wr_fall || read_active) begin
      done_n_d = 1'b1;
    end
    // [R8] completion wins over a clear
    if (sar_done) begin
      result_d = sar_code;
      done_n_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_q <= `ACV_RESULT_RST;
      done_n_q <= `ACV_DONE_N_RST;
    end else if (clk_en_i) begin
      result_q <= result_d;
      done_n_q <= done_n_d;
    end
  end

  // [R4] flag held by its register
  assign conversion_done_n_o = done_n_q;
  assign result_bus_o = result_q;
  // [R11] drive only while read low
  assign result_bus_oe_o = read_active;

  // ==========================================================
  // checks
  // ==========================================================
  logic [12:0] conv_cnt_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_cnt_q <= 13'h0000;
    end else if (clk_en_i) begin
      if (sar_start) begin
        conv_cnt_q <= 13'h0001;
      // stops at completion so the bound also holds once idle
      end else if (sar_busy && !sar_done) begin
        conv_cnt_q <= conv_cnt_q + 13'h0001;
      end
    end
  end

  // [R9] conversion time bound
  conv_time_bound_a: // [R9]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      conv_cnt_q <= 13'(`ACV_CONV_CYC))
    else $error("conversion ran past its time limit");

  // [R8] result and flag at completion
  done_flag_low_a: // [R8]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      sar_done && clk_en_i |=> !conversion_done_n_o && result_bus_o == $past(sar_code))
    else $error("completion did not load result and lower flag");

  // [R5] falling load strobe
  wr_fall_clear_a: // [R5]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      wr_fall && !sar_done && clk_en_i |=> conversion_done_n_o && converting_o == $past(sar_busy))
    else $error("load strobe fall did not raise flag");

  // [R10] read raises flag and drives
  read_clear_a: // [R10]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      read_active && !sar_done && clk_en_i |-> result_bus_oe_o ##1 conversion_done_n_o)
    else $error("read did not raise flag or drive bus");

  // [R11] bus released after read
  bus_release_a: // [R11]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $rose(host_i.rd_b) |-> !result_bus_oe_o)
    else $error("bus still driven after read strobe rose");

  // [R6] capture of the address
  addr_capture_a: // [R6]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      wr_rise && host_i.rd_b && clk_en_i |=>
        mux_cfg_o == $past(result_bus_i[4:0]) && converting_o)
    else $error("address not captured or conversion not started");

  // [R7] retained setting
  addr_retain_a: // [R7]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      wr_rise && !host_i.rd_b && clk_en_i |=> $stable(mux_cfg_o))
    else $error("multiplexer setting changed on a read-held load");

  // [R4] flag held until read
  flag_hold_a: // [R4]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      !conversion_done_n_o && !wr_fall && !read_active |=> !conversion_done_n_o)
    else $error("completion flag rose without a read");

  // [R12] all-zero code
  zero_code_a: // [R12]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mux_neg >= mux_pos |-> mux_diff == 8'h00)
    else $error("nonzero difference with negative input at or above positive");

  // [R13] reference per mode
  mode_ref_a: // [R13]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (cfg_q[3:2] == 2'h1 |-> mux_neg == 8'h00) and
      (cfg_q[3:2] == 2'h3 |-> mux_neg == ch_sample_i[3]))
    else $error("wrong reference input for the selected mode");

  // [R1] latch steers selection
  mux_follow_a: // [R1]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      cfg_q[3:2] == 2'h1 |-> mux_pos == ch_sample_i[cfg_q[1:0]])
    else $error("selected channel does not follow the address latch");

  // [R2] address lines ignored while read low
  addr_ignore_a: // [R2]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      !host_i.rd_b && clk_en_i |=> mux_cfg_o == $past(mux_cfg_o))
    else $error("address latch loaded while read strobe low");

  // [R9] completion at the bound
  done_time_exact_a: // [R9]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      sar_done |-> conv_cnt_q == 13'(`ACV_CONV_CYC))
    else $error("completion not at the conversion time");

  // [R9] busy until completion
  busy_hold_a: // [R9]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      converting_o && !sar_done && clk_en_i |=> converting_o)
    else $error("conversion stopped before completion");

  // [R8] idle after completion
  busy_end_a: // [R8]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      sar_done && clk_en_i |=> !converting_o)
    else $error("conversion still running after completion");

  // [R8] result only at completion
  result_stable_a: // [R8]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      !sar_done |=> $stable(result_bus_o))
    else $error("result changed without a completion");

  // [R4] flag rises on a clear only
  flag_rise_cause_a: // [R4]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $rose(conversion_done_n_o) |-> $past(wr_fall || read_active))
    else $error("completion flag rose without a load or read");

  // [R4] frozen while disabled
  freeze_hold_a: // [R4]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      !clk_en_i |=> $stable(conversion_done_n_o) && $stable(result_bus_o) &&
        $stable(mux_cfg_o) && $stable(converting_o))
    else $error("state moved while the clock enable was low");

  // [R6] latch loads on capture only
  cfg_change_cause_a: // [R6]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      !(wr_rise && host_i.rd_b) |=> $stable(mux_cfg_o))
    else $error("address latch changed without a capture");

  // [R7] retained load still starts
  start_retain_a: // [R7]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      wr_rise && !host_i.rd_b && clk_en_i |=> converting_o)
    else $error("read-held load did not start a conversion");

  // [R3] strobe state one-hot
  ctl_onehot_a: // [R3]
    assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $onehot(ctl_q))
    else $error("strobe decode state not one-hot");

endmodule
`default_nettype wire

// file: sim/acv_host_model.sv
// Purpose: host processor model on the converter control bus
// Assumes: strobes change at the falling edge of mclk_i
// Notes: a released bus shows the inverse of its last driven level
`timescale 1ns/1ns
`default_nettype none
module acv_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] dev_bus_i,
  input wire logic dev_oe_i,
  output acv_pkg::acv_host_s host_o,
  output logic [7:0] bus_o
);
  import acv_pkg::*;
  logic [7:0] addr;
  logic drv;
  logic [7:0] last_q = 8'h00;
  initial begin
    host_o = '{cs_b: 1'b1, wr_b: 1'b1, rd_b: 1'b1};
    drv = 1'b0;
    addr = 8'h00;
  end
  // ==========
  // bus resolution
  always_comb begin
    if (dev_oe_i) begin
      bus_o = dev_bus_i;
    end else if (drv) begin
      bus_o = addr;
    end else begin
      bus_o = ~last_q;
    end
  end
  always @(posedge mclk_i) begin
    if (dev_oe_i || drv) begin
      last_q <= bus_o;
    end
  end
  // ==========
  // strobes
  // start under chip select, address driven while read high
  task automatic wr_fall(input logic [4:0] a, input logic keep);
    @(negedge mclk_i);
    addr = {3'h5, a};
    drv = !keep;
    host_o = '{cs_b: 1'b0, wr_b: 1'b0, rd_b: !keep};
  endtask
  task automatic wr_rise();
    @(negedge mclk_i);
    host_o.wr_b = 1'b1;
  endtask
  task automatic rd_low();
    @(negedge mclk_i);
    host_o = '{cs_b: 1'b0, wr_b: 1'b1, rd_b: 1'b0};
  endtask
  task automatic idle();
    @(negedge mclk_i);
    host_o = '{cs_b: 1'b1, wr_b: 1'b1, rd_b: 1'b1};
    drv = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_adc_bus_conversion_control.sv
// Purpose: self-checking bench of the converter bus control
// Assumes: 100 MHz clock, completion 4000 cycles after the start edge
// Notes: inputs change at the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb_adc_bus_conversion_control;
  import acv_pkg::*;
  logic mclk_i, rst_b_i, clk_en_i;
  acv_host_s host;
  logic [7:0] bus, res_o;
  logic oe, done_n, conv;
  acv_chan_t ch;
  acv_cfg_t cfg;
  int fail_count = 0;
  int n_tests = 0;

  acv_ctrl u_acv_ctrl (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .host_i(host), .result_bus_i(bus), .result_bus_o(res_o), .result_bus_oe_o(oe),
    .conversion_done_n_o(done_n), .ch_sample_i(ch), .mux_cfg_o(cfg),
    .converting_o(conv));
  acv_host_model u_acv_host_model (.mclk_i(mclk_i), .dev_bus_i(res_o), .dev_oe_i(oe),
    .host_o(host), .bus_o(bus));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ==========
  // checking
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========
  // read of a finished result
  task automatic read_back(input logic [7:0] code);
    u_acv_host_model.rd_low();
    #1;
    check("read oe", 8'h01, 8'(oe));
    check("read bus", code, bus);
    @(posedge mclk_i);
    #1;
    check("flag after read", 8'h01, 8'(done_n));
    u_acv_host_model.idle();
    #1;
    check("bus released", 8'h00, 8'(oe));
  endtask

  // one conversion, then an optional read
  task automatic convert(input acv_cfg_t a, input logic keep, input acv_cfg_t ecfg,
                         input logic [7:0] code, input logic do_read);
    int n;
    logic [7:0] prev;
    prev = res_o;
    n = 0;
    u_acv_host_model.wr_fall(a, keep);
    @(posedge mclk_i);
    #1;
    check("flag after start", 8'h01, 8'(done_n));
    if (keep) begin
      check("bus during retain", prev, bus);
    end
    u_acv_host_model.wr_rise();
    @(posedge mclk_i);
    #1;
    check("mux cfg", 8'(ecfg), 8'(cfg));
    check("converting", 8'h01, 8'(conv));
    u_acv_host_model.idle();
    while (done_n !== 1'b0 && n < 4100) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 4100) begin
      check("completion", 8'h00, 8'h01);
      summarize();
    end else begin
      check("within time", 8'h01, 8'(n > 0 && n <= 4000));
      check("result", code, res_o);
      repeat (20) @(posedge mclk_i);
      #1;
      check("flag held", 8'h00, 8'(done_n));
      check("idle after done", 8'h00, 8'(conv));
      if (do_read) begin
        read_back(code);
      end
    end
  endtask

  // ==========
  // scenarios
  task automatic t_reset();
    check("reset flag", 8'h01, 8'(done_n));
    check("reset cfg", 8'h00, 8'(cfg));
    check("reset result", 8'h00, res_o);
    $display("reset test done");
  endtask
  task automatic t_pseudo();
    convert(5'h0C, 1'b0, 5'h0C, 8'h50, 1'b1);
    $display("pseudo-differential test done");
  endtask
  task automatic t_single();
    convert(5'h05, 1'b0, 5'h05, 8'hA5, 1'b1);
    $display("single-ended test done");
  endtask
  task automatic t_retain();
    @(negedge mclk_i);
    ch[1] = 8'h77;
    convert(5'h1F, 1'b1, 5'h05, 8'h77, 1'b1);
    $display("retained setting test done");
  endtask
  task automatic t_diff();
    @(negedge mclk_i);
    ch[0] = 8'h20;
    convert(5'h00, 1'b0, 5'h00, 8'h00, 1'b0);
    convert(5'h01, 1'b0, 5'h01, 8'h57, 1'b0);
    $display("differential test done");
  endtask
  task automatic t_freeze();
    @(negedge mclk_i);
    clk_en_i = 1'b0;
    u_acv_host_model.rd_low();
    #1;
    check("frozen oe", 8'h01, 8'(oe));
    @(posedge mclk_i);
    #1;
    check("frozen flag", 8'h00, 8'(done_n));
    @(negedge mclk_i);
    clk_en_i = 1'b1;
    @(posedge mclk_i);
    #1;
    check("flag after enable", 8'h01, 8'(done_n));
    u_acv_host_model.idle();
    $display("clock enable test done");
  endtask
  task automatic t_pair();
    convert(5'h0B, 1'b0, 5'h0B, 8'h10, 1'b1);
    $display("second pair test done");
  endtask

  initial begin
    rst_b_i = 1'b0;
    clk_en_i = 1'b1;
    ch = {8'h40, 8'h30, 8'hA5, 8'h90};
    repeat (2) @(negedge mclk_i);
    rst_b_i = 1'b1;
    t_reset();
    t_pseudo();
    t_single();
    t_retain();
    t_diff();
    t_freeze();
    t_pair();
    summarize();
  end
endmodule
`default_nettype wire
